// ===== inc/clio_pkg.sv
/*
 * Package for the camera line I/O control block: register indices,
 * field widths, reset values and the output origin enumeration.
 * Assumes a plain register port with word-wide data, one clock.
 */
package clio_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_PINS    = 4;
    localparam int NUM_SOFT    = 4;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int SEL_W       = 2;
    localparam int CLASS_W     = 8;
    localparam int CONF_W      = 16;
    localparam int ORIGIN_W    = 4;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [ADDR_W-1:0] PIN_CHOOSER_ADDR     = 8'h00;
    localparam logic [ADDR_W-1:0] PIN_DIRECTION_ADDR   = 8'h04;
    localparam logic [ADDR_W-1:0] PIN_POLARITY_ADDR    = 8'h08;
    localparam logic [ADDR_W-1:0] PIN_LEVEL_ADDR       = 8'h0c;
    localparam logic [ADDR_W-1:0] ALL_PIN_LEVELS_ADDR  = 8'h10;
    localparam logic [ADDR_W-1:0] PIN_ORIGIN_ADDR      = 8'h14;
    localparam logic [ADDR_W-1:0] AUX_RAIL_ADDR        = 8'h18;
    localparam logic [ADDR_W-1:0] SOFT_CHOOSER_ADDR    = 8'h1c;
    localparam logic [ADDR_W-1:0] SOFT_LEVEL_ADDR      = 8'h20;
    localparam logic [ADDR_W-1:0] ALL_SOFT_LEVELS_ADDR = 8'h24;
    localparam logic [ADDR_W-1:0] MATCH_CLASS_ADDR     = 8'h28;
    localparam logic [ADDR_W-1:0] CONF_FLOOR_ADDR      = 8'h2c;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [CLASS_W-1:0] MATCH_CLASS_RST = 8'h00;
    localparam logic [CONF_W-1:0]  CONF_FLOOR_RST  = 16'hffff;

    // ************************************************************
    // Output origin codes, in documented order
    // ************************************************************
    typedef enum logic [ORIGIN_W-1:0] {
        ORG_OFF, ORG_PIN0, ORG_PIN1, ORG_PIN2, ORG_PIN3,
        ORG_SOFT0, ORG_SOFT1, ORG_SOFT2, ORG_SOFT3,
        ORG_EXPOSING, ORG_TRIG_ARMED, ORG_CLASS_HIT, ORG_UART_TX
    } clio_origin_t;

endpackage : clio_pkg

// ===== inc/clio_cls_if.sv
/*
 * Interface carrying per-pin classifier settings to the hit comparator
 * and the hit flags back. Assumes one clock domain.
 */
interface clio_cls_if;
    logic [clio_pkg::NUM_PINS-1:0][clio_pkg::CLASS_W-1:0] match_class;
    logic [clio_pkg::NUM_PINS-1:0][clio_pkg::CONF_W-1:0]  conf_floor;
    logic [clio_pkg::CLASS_W-1:0]                          rep_class;
    logic [clio_pkg::CONF_W-1:0]                           rep_conf;
    logic                                                  rep_valid;
    logic [clio_pkg::NUM_PINS-1:0]                         hit;

    modport ctrl (output match_class, output conf_floor, output rep_class,
                  output rep_conf, output rep_valid, input hit);
    modport cmp  (input match_class, input conf_floor, input rep_class,
                  input rep_conf, input rep_valid, output hit);
endinterface : clio_cls_if

// ===== rtl/clio_hit_cmp.sv
/*
 * Per-pin classifier hit comparator with registered hit flags.
 * Assumes reported class and confidence are synchronous to ref_clk.
 */
module clio_hit_cmp (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    clio_cls_if.cmp   cls
);

    typedef struct packed {
        logic [clio_pkg::NUM_PINS-1:0] hit;
    } clio_cmp_state_t;

    clio_cmp_state_t st_reg;
    clio_cmp_state_t st_next;

    // Hit when class matches and confidence reaches floor
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < clio_pkg::NUM_PINS; i++) begin
            st_next.hit[i] = cls.rep_valid
                && (cls.rep_class == cls.match_class[i])
                && (cls.rep_conf >= cls.conf_floor[i]);
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign cls.hit = st_reg.hit;

    chk_hit_follows_match: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && cls.rep_valid && cls.rep_class == cls.match_class[0]
        && cls.rep_conf >= cls.conf_floor[0] |=> cls.hit[0])
        else $error("hit flag missing for matching class");

endmodule : clio_hit_cmp

// ===== rtl/clio_line_ctrl.sv
/*
 * Camera connector line I/O control: four lines with direction,
 * polarity, output origin select, level readback, soft outputs,
 * classifier match settings and aux rail switch.
 * Assumes a plain register port and pins synchronous to ref_clk.
 */
// The strobed register port and the register offsets are this design's own decisions.
module clio_line_ctrl (
    input  wire logic                               ref_clk,
    input  wire logic                               arst_n,
    input  wire logic                               clk_en,
    input  wire logic [clio_pkg::ADDR_W-1:0]        reg_addr,
    input  wire logic [clio_pkg::DATA_W-1:0]        reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [clio_pkg::DATA_W-1:0]        reg_rdata,
    input  wire logic [clio_pkg::NUM_PINS-1:0]      pin_in,
    output logic      [clio_pkg::NUM_PINS-1:0]      pin_out,
    output logic      [clio_pkg::NUM_PINS-1:0]      pin_oe_n,
    output logic                                    aux_rail_switch,
    input  wire logic                               sensor_exposing_flag,
    input  wire logic                               trigger_armed_flag,
    input  wire logic                               uart_tx_path,
    input  wire logic [clio_pkg::CLASS_W-1:0]       classifier_class,
    input  wire logic [clio_pkg::CONF_W-1:0]        classifier_conf,
    input  wire logic                               classifier_valid
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [clio_pkg::SEL_W-1:0]                              pin_chooser;
        logic [clio_pkg::NUM_PINS-1:0]                           pin_direction;
        logic [clio_pkg::NUM_PINS-1:0]                           pin_polarity_flip;
        logic [clio_pkg::NUM_PINS-1:0][clio_pkg::ORIGIN_W-1:0]   pin_output_origin;
        logic                                                    aux_rail;
        logic [clio_pkg::SEL_W-1:0]                              soft_output_chooser;
        logic [clio_pkg::NUM_SOFT-1:0]                           soft_levels;
        logic [clio_pkg::NUM_PINS-1:0][clio_pkg::CLASS_W-1:0]    match_class;
        logic [clio_pkg::NUM_PINS-1:0][clio_pkg::CONF_W-1:0]     conf_floor;
        logic [clio_pkg::NUM_PINS-1:0]                           pin_out;
        logic [clio_pkg::NUM_PINS-1:0]                           pin_oe_n;
        logic [clio_pkg::NUM_PINS-1:0]                           levels;
        logic [clio_pkg::DATA_W-1:0]                             rdata;
    } clio_state_t;

    localparam clio_state_t ST_RST = '{
        pin_chooser:         '0,
        pin_direction:       '0,
        pin_polarity_flip:   '0,
        pin_output_origin:   '0,
        aux_rail:            1'b0,
        soft_output_chooser: '0,
        soft_levels:         '0,
        match_class:         {clio_pkg::NUM_PINS{clio_pkg::MATCH_CLASS_RST}},
        conf_floor:          {clio_pkg::NUM_PINS{clio_pkg::CONF_FLOOR_RST}},
        pin_out:             '0,
        pin_oe_n:            '1,
        levels:              '0,
        rdata:               '0
    };

    clio_state_t st_reg;
    clio_state_t st_next;

    // ************************************************************
    // Classifier comparator
    // ************************************************************
    clio_cls_if cls ();

    assign cls.match_class = st_reg.match_class;
    assign cls.conf_floor  = st_reg.conf_floor;
    assign cls.rep_class   = classifier_class;
    assign cls.rep_conf    = classifier_conf;
    assign cls.rep_valid   = classifier_valid;

    clio_hit_cmp u_hit (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .cls     (cls)
    );

    // ************************************************************
    // Pin levels and origin mux
    // ************************************************************
    logic [clio_pkg::NUM_PINS-1:0] line_level;
    logic [clio_pkg::NUM_PINS-1:0] origin_sig;

    // Pin level as seen logically: inputs take the pad value with polarity applied, outputs the origin source before polarity
    always_comb begin
        for (int i = 0; i < clio_pkg::NUM_PINS; i++) begin
            if (st_reg.pin_direction[i]) begin
                line_level[i] = origin_sig[i];
            end else begin
                line_level[i] = pin_in[i] ^ st_reg.pin_polarity_flip[i];
            end
        end
    end

    // Origin select per pin
    for (genvar g = 0; g < clio_pkg::NUM_PINS; g++) begin : g_origin
        logic src;

        always_comb begin
            case (clio_pkg::clio_origin_t'(st_reg.pin_output_origin[g]))
                clio_pkg::ORG_PIN0:       src = pin_in[0];
                clio_pkg::ORG_PIN1:       src = pin_in[1];
                clio_pkg::ORG_PIN2:       src = pin_in[2];
                clio_pkg::ORG_PIN3:       src = pin_in[3];
                clio_pkg::ORG_SOFT0:      src = st_reg.soft_levels[0];
                clio_pkg::ORG_SOFT1:      src = st_reg.soft_levels[1];
                clio_pkg::ORG_SOFT2:      src = st_reg.soft_levels[2];
                clio_pkg::ORG_SOFT3:      src = st_reg.soft_levels[3];
                clio_pkg::ORG_EXPOSING:   src = sensor_exposing_flag;
                clio_pkg::ORG_TRIG_ARMED: src = trigger_armed_flag;
                clio_pkg::ORG_CLASS_HIT:  src = cls.hit[g];
                clio_pkg::ORG_UART_TX:    src = uart_tx_path;
                default:                  src = 1'b0;
            endcase
        end

        assign origin_sig[g] = src;
    end

    // ************************************************************
    // Next state: register writes, reads, pin drive
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        // Register writes, per-line fields indexed by the chooser
        if (reg_wr) begin
            case (reg_addr)
                clio_pkg::PIN_CHOOSER_ADDR:
                    st_next.pin_chooser = reg_wdata[clio_pkg::SEL_W-1:0];
                clio_pkg::PIN_DIRECTION_ADDR:
                    st_next.pin_direction[st_reg.pin_chooser] = reg_wdata[0];
                clio_pkg::PIN_POLARITY_ADDR:
                    st_next.pin_polarity_flip[st_reg.pin_chooser] = reg_wdata[0];
                clio_pkg::PIN_ORIGIN_ADDR:
                    st_next.pin_output_origin[st_reg.pin_chooser] =
                        reg_wdata[clio_pkg::ORIGIN_W-1:0];
                clio_pkg::AUX_RAIL_ADDR:
                    st_next.aux_rail = reg_wdata[0];
                clio_pkg::SOFT_CHOOSER_ADDR:
                    st_next.soft_output_chooser = reg_wdata[clio_pkg::SEL_W-1:0];
                clio_pkg::SOFT_LEVEL_ADDR:
                    st_next.soft_levels[st_reg.soft_output_chooser] = reg_wdata[0];
                clio_pkg::MATCH_CLASS_ADDR:
                    st_next.match_class[st_reg.pin_chooser] =
                        reg_wdata[clio_pkg::CLASS_W-1:0];
                clio_pkg::CONF_FLOOR_ADDR:
                    st_next.conf_floor[st_reg.pin_chooser] =
                        reg_wdata[clio_pkg::CONF_W-1:0];
                default: ;
            endcase
        end
        // Read data valid only the cycle after the strobe
        st_next.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                clio_pkg::PIN_CHOOSER_ADDR:
                    st_next.rdata[clio_pkg::SEL_W-1:0] = st_reg.pin_chooser;
                clio_pkg::PIN_DIRECTION_ADDR:
                    st_next.rdata[0] = st_reg.pin_direction[st_reg.pin_chooser];
                clio_pkg::PIN_POLARITY_ADDR:
                    st_next.rdata[0] = st_reg.pin_polarity_flip[st_reg.pin_chooser];
                clio_pkg::PIN_LEVEL_ADDR:
                    st_next.rdata[0] = st_reg.levels[st_reg.pin_chooser];
                clio_pkg::ALL_PIN_LEVELS_ADDR:
                    st_next.rdata[clio_pkg::NUM_PINS-1:0] = st_reg.levels;
                clio_pkg::PIN_ORIGIN_ADDR:
                    st_next.rdata[clio_pkg::ORIGIN_W-1:0] =
                        st_reg.pin_output_origin[st_reg.pin_chooser];
                clio_pkg::AUX_RAIL_ADDR:
                    st_next.rdata[0] = st_reg.aux_rail;
                clio_pkg::SOFT_CHOOSER_ADDR:
                    st_next.rdata[clio_pkg::SEL_W-1:0] = st_reg.soft_output_chooser;
                clio_pkg::SOFT_LEVEL_ADDR:
                    st_next.rdata[0] = st_reg.soft_levels[st_reg.soft_output_chooser];
                clio_pkg::ALL_SOFT_LEVELS_ADDR:
                    st_next.rdata[clio_pkg::NUM_SOFT-1:0] = st_reg.soft_levels;
                clio_pkg::MATCH_CLASS_ADDR:
                    st_next.rdata[clio_pkg::CLASS_W-1:0] =
                        st_reg.match_class[st_reg.pin_chooser];
                clio_pkg::CONF_FLOOR_ADDR:
                    st_next.rdata[clio_pkg::CONF_W-1:0] =
                        st_reg.conf_floor[st_reg.pin_chooser];
                default: ;
            endcase
        end
        // Pin drive; all levels sampled together in one edge
        for (int i = 0; i < clio_pkg::NUM_PINS; i++) begin
            st_next.pin_oe_n[i] = ~st_reg.pin_direction[i];
            st_next.pin_out[i]  = st_reg.pin_direction[i]
                                  & (origin_sig[i] ^ st_reg.pin_polarity_flip[i]);
        end
        st_next.levels = line_level;
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign reg_rdata       = st_reg.rdata;
    assign pin_out         = st_reg.pin_out;
    assign pin_oe_n        = st_reg.pin_oe_n;
    assign aux_rail_switch = st_reg.aux_rail;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_dir_write(int v);
        clk_en && reg_wr && reg_addr == clio_pkg::PIN_DIRECTION_ADDR
        && st_reg.pin_chooser == 2'h0 && reg_wdata[0] == v[0];
    endsequence

    sequence s_pin0_plain_origin(int code);
        clk_en && st_reg.pin_direction[0] && !st_reg.pin_polarity_flip[0]
        && st_reg.pin_output_origin[0] == code[clio_pkg::ORIGIN_W-1:0];
    endsequence

    chk_pin_chooser_wr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == clio_pkg::PIN_CHOOSER_ADDR
        |=> st_reg.pin_chooser == $past(reg_wdata[1:0]))
        else $error("pin chooser not updated");

    chk_input_no_drive: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_dir_write(0) ##1 clk_en |=> pin_oe_n[0] && !pin_out[0])
        else $error("input pin still driven");

    chk_output_drive: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_dir_write(1) ##1 clk_en |=> !pin_oe_n[0])
        else $error("output pin not driven");

    chk_polarity_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && st_reg.pin_direction[0] |=>
        pin_out[0] == ($past(origin_sig[0]) ^ $past(st_reg.pin_polarity_flip[0])))
        else $error("output polarity wrong");

    chk_level_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_rd && reg_addr == clio_pkg::PIN_LEVEL_ADDR
        |=> reg_rdata == {31'h0, $past(st_reg.levels[st_reg.pin_chooser])})
        else $error("pin level readback wrong");

    chk_all_levels: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_rd && reg_addr == clio_pkg::ALL_PIN_LEVELS_ADDR
        |=> reg_rdata == {28'h0, $past(st_reg.levels)})
        else $error("all levels word wrong");

    chk_aux_rail: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == clio_pkg::AUX_RAIL_ADDR
        |=> aux_rail_switch == $past(reg_wdata[0]))
        else $error("aux rail switch not updated");

    chk_soft_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == clio_pkg::SOFT_LEVEL_ADDR
        |=> st_reg.soft_levels[$past(st_reg.soft_output_chooser)] == $past(reg_wdata[0]))
        else $error("soft level not stored");

    chk_soft_all: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_rd && reg_addr == clio_pkg::ALL_SOFT_LEVELS_ADDR
        |=> reg_rdata == {28'h0, $past(st_reg.soft_levels)})
        else $error("soft levels word wrong");

    chk_loopback: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_pin0_plain_origin(clio_pkg::ORG_PIN1)
        |=> pin_out[0] == $past(pin_in[1]))
        else $error("loopback level wrong");

    // ************************************************************
    // Checks on origins, settings and readback
    // ************************************************************
    chk_origin_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_pin0_plain_origin(clio_pkg::ORG_OFF)
        |=> !pin_out[0])
        else $error("off origin drives high");

    chk_exposing_src: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_pin0_plain_origin(clio_pkg::ORG_EXPOSING)
        |=> pin_out[0] == $past(sensor_exposing_flag))
        else $error("exposing origin wrong");

    chk_armed_src: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_pin0_plain_origin(clio_pkg::ORG_TRIG_ARMED)
        |=> pin_out[0] == $past(trigger_armed_flag))
        else $error("armed origin wrong");

    chk_uart_src: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_pin0_plain_origin(clio_pkg::ORG_UART_TX)
        |=> pin_out[0] == $past(uart_tx_path))
        else $error("uart origin wrong");

    chk_soft_chooser_wr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == clio_pkg::SOFT_CHOOSER_ADDR
        |=> st_reg.soft_output_chooser == $past(reg_wdata[clio_pkg::SEL_W-1:0]))
        else $error("soft chooser not updated");

    chk_match_class_wr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == clio_pkg::MATCH_CLASS_ADDR
        |=> st_reg.match_class[$past(st_reg.pin_chooser)]
            == $past(reg_wdata[clio_pkg::CLASS_W-1:0]))
        else $error("match class not stored");

    chk_conf_floor_wr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == clio_pkg::CONF_FLOOR_ADDR
        |=> st_reg.conf_floor[$past(st_reg.pin_chooser)]
            == $past(reg_wdata[clio_pkg::CONF_W-1:0]))
        else $error("confidence floor not stored");

    chk_level_input: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && !st_reg.pin_direction[0] && !st_reg.pin_polarity_flip[0]
        |=> st_reg.levels[0] == $past(pin_in[0]))
        else $error("input level not pad level");

    chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && !reg_rd
        |=> reg_rdata == '0)
        else $error("read data outside its cycle");

endmodule : clio_line_ctrl

// ===== verif/clio_far_side.sv
/*
 * Model of the external equipment wired to the four connector lines.
 * Assumes pull-ups on the pads; the device drives a line while its enable is low.
 */
module clio_far_side (
    input  wire logic [clio_pkg::NUM_PINS-1:0] pin_out,
    input  wire logic [clio_pkg::NUM_PINS-1:0] pin_oe_n,
    input  wire logic [clio_pkg::NUM_PINS-1:0] ext_en,
    input  wire logic [clio_pkg::NUM_PINS-1:0] ext_val,
    output logic      [clio_pkg::NUM_PINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pad level: device first, then equipment, else the pull-up
    always_comb begin
        for (int i = 0; i < clio_pkg::NUM_PINS; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
        end
    end
endmodule : clio_far_side

// ===== verif/clio_line_ctrl_bench.sv
/*
 * Self-checking bench for the connector line control block.
 * Assumes the far-side model, one 100 MHz clock and a 16-cycle reset.
 */
module clio_line_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } clio_row_t;

    logic        ref_clk = 1'h0;
    logic        arst_n = 1'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'h0;
    logic        reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic [3:0]  pin_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe_n;
    logic        aux_rail_switch;
    logic        sensor_exposing_flag = 1'h1;
    logic        trigger_armed_flag = 1'h0;
    logic        uart_tx_path = 1'h1;
    logic [7:0]  classifier_class = 8'h33;
    logic [15:0] classifier_conf = 16'h1234;
    logic        classifier_valid = 1'h1;
    logic [3:0]  ext_val = 4'ha;
    logic [3:0]  ext_en = 4'hf;
    logic        clk_en = 1'h1;
    logic [31:0] rd_val;
    logic [13:0] exp_vec = 14'h1ab4; // Expected source level per origin code
    int          err_total = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    clio_row_t   rows [31] = '{
        '{1'h0, 8'h00, 32'h0}, '{1'h0, 8'h04, 32'h0}, '{1'h0, 8'h08, 32'h0},
        '{1'h0, 8'h14, 32'h0}, '{1'h0, 8'h18, 32'h0}, '{1'h0, 8'h28, 32'h0},
        '{1'h0, 8'h2c, 32'hffff}, '{1'h0, 8'h24, 32'h0}, '{1'h1, 8'h00, 32'hfffffffe},
        '{1'h1, 8'h04, 32'h1}, '{1'h1, 8'h08, 32'h1}, '{1'h1, 8'h14, 32'h5},
        '{1'h1, 8'h28, 32'h33}, '{1'h1, 8'h2c, 32'h1234}, '{1'h1, 8'h18, 32'h1},
        '{1'h0, 8'h00, 32'h2}, '{1'h0, 8'h04, 32'h1}, '{1'h0, 8'h08, 32'h1},
        '{1'h0, 8'h14, 32'h5}, '{1'h0, 8'h28, 32'h33}, '{1'h0, 8'h2c, 32'h1234},
        '{1'h0, 8'h18, 32'h1}, '{1'h1, 8'h04, 32'h0}, '{1'h1, 8'h00, 32'h0},
        '{1'h0, 8'h04, 32'h0}, '{1'h0, 8'h14, 32'h0}, '{1'h0, 8'h2c, 32'hffff},
        '{1'h1, 8'h24, 32'hf}, '{1'h0, 8'h24, 32'h0}, '{1'h1, 8'h40, 32'hffffffff},
        '{1'h0, 8'h40, 32'h0}};

    clio_line_ctrl u_clio_line_ctrl (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .aux_rail_switch(aux_rail_switch), .sensor_exposing_flag(sensor_exposing_flag),
        .trigger_armed_flag(trigger_armed_flag), .uart_tx_path(uart_tx_path),
        .classifier_class(classifier_class), .classifier_conf(classifier_conf),
        .classifier_valid(classifier_valid));

    clio_far_side u_clio_far_side (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // ************************************************************
    // Clock, timeout and helper tasks
    // ************************************************************
    always #5 ref_clk = ~ref_clk;

    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 rd_val = reg_rdata;
        check(rd_val, want);
    endtask : rd_chk

    task automatic settle_pin0(input logic [31:0] want);
        repeat (3) @(posedge ref_clk);
        #1;
        check(32'(pin_out[0]), want);
    endtask : settle_pin0

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'h1;
        check(32'(pin_oe_n), 32'hf);
        check(32'(pin_out), 32'h0);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].data);
            end else begin
                rd_chk(rows[i].addr, rows[i].data);
            end
        end
        check(32'(aux_rail_switch), 32'h1);
        // Soft outputs become 4'b0101
        for (int k = 0; k < 4; k++) begin
            wr(8'h1c, 32'(k));
            wr(8'h20, 32'(~k & 1));
        end
        rd_chk(8'h24, 32'h5);
        wr(8'h28, 32'h33);
        wr(8'h2c, 32'h1234);
        wr(8'h04, 32'h1);
        // Every origin code on line 0 in both polarities, self loopback skipped
        for (int c = 0; c < 14; c++) begin
            for (int p = 0; p < 2; p++) begin
                if (c != 1) begin
                    wr(8'h14, 32'(c));
                    wr(8'h08, 32'(p));
                    settle_pin0(32'(exp_vec[c] ^ p[0]));
                    check(32'(pin_oe_n[0]), 32'h0);
                    rd_chk(8'h0c, 32'(exp_vec[c]));
                end
            end
        end
        // Hit boundaries: floor minus one, wrong class, not valid, exact floor
        wr(8'h14, 32'hb);
        wr(8'h08, 32'h0);
        for (int t = 0; t < 4; t++) begin
            classifier_class <= (t == 1) ? 8'h34 : 8'h33;
            classifier_conf <= (t == 0) ? 16'h1233 : 16'h1234;
            classifier_valid <= (t != 2);
            settle_pin0(32'(t == 3));
        end
        sensor_exposing_flag <= 1'h0;
        trigger_armed_flag <= 1'h1;
        wr(8'h14, 32'h9);
        settle_pin0(32'h0);
        wr(8'h14, 32'ha);
        settle_pin0(32'h1);
        // Line 1 stays input while its origin and polarity are set
        wr(8'h00, 32'h1);
        wr(8'h14, 32'h5);
        wr(8'h08, 32'h1);
        repeat (3) @(posedge ref_clk);
        check(32'({pin_oe_n[1], pin_out[1]}), 32'h2);
        rd_chk(8'h0c, 32'h0);
        rd_chk(8'h10, 32'hd);
        // Line 0 back to input, pads change, line 3 left to its pull-up
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        @(posedge ref_clk);
        ext_val <= 4'h5;
        ext_en <= 4'h7;
        rd_chk(8'h10, 32'hb);
        check(32'(pin_oe_n[0]), 32'h1);
        // Clock enable low freezes the rail switch
        @(posedge ref_clk);
        clk_en <= 1'h0;
        wr(8'h18, 32'h0);
        @(posedge ref_clk);
        check(32'(aux_rail_switch), 32'h1);
        clk_en <= 1'h1;
        // Reset in mid-run restores reset values
        @(posedge ref_clk);
        arst_n <= 1'h0;
        @(posedge ref_clk);
        check(32'({aux_rail_switch, pin_oe_n, pin_out}), 32'h0f0);
        arst_n <= 1'h1;
        rd_chk(8'h2c, 32'hffff);
        rd_chk(8'h24, 32'h0);
        give_verdict();
    end
endmodule : clio_line_ctrl_bench
